// ### common/cmfc_pkg.sv
package cmfc_pkg;
    localparam logic [7:0]  CMFC_OFS_MASK_LOW  = 8'h00;
    localparam logic [7:0]  CMFC_OFS_MASK_HIGH = 8'h04;
    localparam logic [7:0]  CMFC_OFS_CTRL_BASE = 8'h80;
    localparam logic [15:0] CMFC_MASK_LOW_RST  = 16'h0000;
    localparam logic [15:0] CMFC_MASK_HIGH_RST = 16'h0000;
    localparam logic [15:0] CMFC_MASK_HIGH_WR  = 16'hE3FF;
    localparam int          CMFC_MAILBOXES     = 16;
    localparam int          CMFC_CTRL_BYTES    = 8;
    localparam logic [3:0]  CMFC_DLC_MAX       = 4'h8;
    localparam int          CMFC_RTR_BIT       = 4;
    localparam int          CMFC_IDE_BIT       = 3;
    localparam int          CMFC_IDX_DLC       = 0;
    localparam int          CMFC_IDX_ID_20_16  = 4;
    localparam int          CMFC_IDX_ID_28_21  = 5;
    localparam int          CMFC_IDX_ID_7_0    = 6;
    localparam int          CMFC_IDX_ID_15_8   = 7;
    localparam logic [28:0] CMFC_STD_CARE      = 29'h1FFC_0000;
endpackage

// ### verilog/cmfc_filter.sv
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module cmfc_filter #(
    parameter int MAILBOXES  = cmfc_pkg::CMFC_MAILBOXES,
    parameter int CTRL_BYTES = cmfc_pkg::CMFC_CTRL_BYTES
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    input  wire logic [28:0] rx_id_i,
    input  wire logic        rx_ext_i,
    input  wire logic        rx_rtr_i,
    input  wire logic        rx_valid_i,
    output logic             mb0_accept_o,
    output logic             mb0_reject_o,
    output logic      [3:0]  mb0_dlc_o,
    output logic             mb0_rtr_o,
    output logic             mb0_ext_o
);
    import cmfc_pkg::*;

    // ****************************************
    // Storage
    // ****************************************
    localparam int RAM_DEPTH = MAILBOXES * CTRL_BYTES;
    localparam int IDX_W     = $clog2(RAM_DEPTH);

    logic [15:0] mask_low_q;
    logic [15:0] mask_high_q;
    logic        ack_q;
    logic [31:0] dat_q;
    logic        acc_q;
    logic        rej_q;
    logic [3:0]  dlc_q;
    logic        rtr_q;
    logic        ext_q;

    // One byte per address: mailbox m byte k sits at the base plus eight times m plus k minus one.
    // There is no reset on this array, so reset leaves the contents as they were, and
    // after power-on they are unknown until software has written every byte.
    logic [7:0]  ctrl_ram [0:RAM_DEPTH-1];

    // ****************************************
    // Helper functions
    // ****************************************
    // Folds a byte-lane write into a 16-bit register, lanes 1 and 0 only.
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] d,
                                            input logic [3:0]  s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // Spreads the two mask registers over identifier bit positions 28 to 0.
    function automatic logic [28:0] mask_to_id(input logic [15:0] lo,
                                               input logic [15:0] hi);
        mask_to_id = {hi[7:0],
                      hi[15:13],
                      hi[9:8],
                      lo[7:0],
                      lo[15:8]};
    endfunction

    // Gathers the configured identifier out of control bytes 5 to 8.
    function automatic logic [28:0] cfg_id(input logic [7:0] b5,
                                           input logic [7:0] b6,
                                           input logic [7:0] b7,
                                           input logic [7:0] b8);
        cfg_id = {b6, b5[7:5], b5[1:0], b8, b7};
    endfunction

    // Length codes above eight still mean eight bytes on the bus.
    function automatic logic [3:0] dlc_cap(input logic [3:0] code);
        dlc_cap = (code > CMFC_DLC_MAX) ? CMFC_DLC_MAX : code;
    endfunction

    // ****************************************
    // Bus decode
    // ****************************************
    // A request is taken once; the registered ack blocks a second take of the same cycle.
    wire             req      = cyc_i && stb_i && !ack_q;
    wire             wr       = req && we_i;
    wire             rd       = req && !we_i;
    wire             hit_low  = (adr_i == CMFC_OFS_MASK_LOW);
    wire             hit_high = (adr_i == CMFC_OFS_MASK_HIGH);
    wire             hit_ctrl = (adr_i >= CMFC_OFS_CTRL_BASE);
    wire [7:0]       ctrl_off = adr_i - CMFC_OFS_CTRL_BASE;
    wire [IDX_W-1:0] ram_idx  = ctrl_off[IDX_W-1:0];
    wire [15:0]      low_d    = merge16(mask_low_q, dat_i, sel_i);
    wire [15:0]      high_d   = merge16(mask_high_q, dat_i, sel_i) & CMFC_MASK_HIGH_WR;
    wire             ram_we   = wr && hit_ctrl && sel_i[0];
    wire [7:0]       ram_rd   = ctrl_ram[ram_idx];

    // Unmapped addresses still ack and read zero, so a stray access never hangs the bus.
    wire [31:0]      rd_word  = hit_low  ? {16'h0000, mask_low_q} :
                                hit_high ? {16'h0000, mask_high_q & CMFC_MASK_HIGH_WR} :
                                hit_ctrl ? {24'h00_0000, ram_rd} :
                                           32'h0000_0000;

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_low_q <= CMFC_MASK_LOW_RST;
        end else if (wr && hit_low) begin
            mask_low_q <= low_d;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_high_q <= CMFC_MASK_HIGH_RST;
        end else if (wr && hit_high) begin
            mask_high_q <= high_d;
        end
    end

    // Written bytes stay put across reset; only a bus write changes them.
    always_ff @(posedge clk_i) begin
        if (ram_we) begin
            ctrl_ram[ram_idx] <= dat_i[7:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // Read data is held until the next read or a reset, which clears it, so software may pick it up late.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (rd) begin
            dat_q <= rd_word;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

    // ****************************************
    // Mailbox 0 acceptance
    // ****************************************
    wire [7:0]  mb0_len_byte = ctrl_ram[CMFC_IDX_DLC];
    wire [7:0]  mb0_b5       = ctrl_ram[CMFC_IDX_ID_20_16];
    wire [7:0]  mb0_b6       = ctrl_ram[CMFC_IDX_ID_28_21];
    wire [7:0]  mb0_b7       = ctrl_ram[CMFC_IDX_ID_7_0];
    wire [7:0]  mb0_b8       = ctrl_ram[CMFC_IDX_ID_15_8];
    wire [28:0] mb_id        = cfg_id(mb0_b5, mb0_b6, mb0_b7, mb0_b8);
    wire [28:0] dont_care    = mask_to_id(mask_low_q, mask_high_q);
    wire        ext_cfg      = mb0_b5[CMFC_IDE_BIT];
    wire        rtr_cfg      = mb0_b5[CMFC_RTR_BIT];
    // A standard frame carries only identifier bits 28 to 18, the rest are not compared.
    wire [28:0] fmt_care     = ext_cfg ? 29'h1FFF_FFFF : CMFC_STD_CARE;
    wire [28:0] id_diff      = (rx_id_i ^ mb_id) & ~dont_care & fmt_care;
    wire        id_ok        = (id_diff == 29'h0000_0000);
    wire        match        = id_ok && (rx_ext_i == ext_cfg);
    wire        take         = rx_valid_i && match;
    wire        drop         = rx_valid_i && !match;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_q <= 1'b0;
            rej_q <= 1'b0;
        end else begin
            acc_q <= take;
            rej_q <= drop;
        end
    end

    // Length and format are captured with each accepted frame; before the first one
    // they read zero instead of the unknown contents of unwritten control bytes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dlc_q <= 4'h0;
            rtr_q <= 1'b0;
            ext_q <= 1'b0;
        end else if (take) begin
            dlc_q <= dlc_cap(mb0_len_byte[3:0]);
            rtr_q <= rtr_cfg;
            ext_q <= ext_cfg;
        end
    end

    assign mb0_accept_o = acc_q;
    assign mb0_reject_o = rej_q;
    assign mb0_dlc_o    = dlc_q;
    assign mb0_rtr_o    = rtr_q;
    assign mb0_ext_o    = ext_q;

    // ****************************************
    // Checks
    // ****************************************
    wire [3:0]  dlc_code = mb0_len_byte[3:0];
    wire [15:0] wr_half  = dat_i[15:0];
    wire [7:0]  wr_byte  = dat_i[7:0];
    wire        full_sel = (sel_i[1:0] == 2'b11);

    // Reserved high mask bits can never be stored, whatever software writes.
    property p_high_reserved;
        @(posedge clk_i) disable iff (rst_i) mask_high_q[12:10] == 3'h0;
    endproperty
    a_high_reserved: assert property (p_high_reserved)
        else $error("reserved mask bits set");

    property p_high_read_zero;
        @(posedge clk_i) disable iff (rst_i) rd && hit_high |=> dat_o[12:10] == 3'h0;
    endproperty
    a_high_read_zero: assert property (p_high_read_zero)
        else $error("reserved mask bits read back");

    // Length checks keep the captured value at most eight and, for codes up to eight, compare it with the raw length code in control byte 1.
    property p_dlc_cap;
        @(posedge clk_i) disable iff (rst_i) mb0_dlc_o <= CMFC_DLC_MAX;
    endproperty
    a_dlc_cap: assert property (p_dlc_cap)
        else $error("length above eight");

    property p_dlc_copy;
        @(posedge clk_i) disable iff (rst_i)
            take && (dlc_code <= CMFC_DLC_MAX) |=> mb0_dlc_o == $past(dlc_code);
    endproperty
    a_dlc_copy: assert property (p_dlc_copy)
        else $error("length not copied");

    property p_dlc_big;
        @(posedge clk_i) disable iff (rst_i)
            take && (dlc_code > CMFC_DLC_MAX) |=> mb0_dlc_o == CMFC_DLC_MAX;
    endproperty
    a_dlc_big: assert property (p_dlc_big)
        else $error("long code not capped");

    // Accept and reject are one-cycle answers to a frame and never both at once.
    property p_accept_cause;
        @(posedge clk_i) disable iff (rst_i) take |=> mb0_accept_o && !mb0_reject_o;
    endproperty
    a_accept_cause: assert property (p_accept_cause)
        else $error("matching frame not accepted");

    property p_reject_cause;
        @(posedge clk_i) disable iff (rst_i) drop |=> mb0_reject_o && !mb0_accept_o;
    endproperty
    a_reject_cause: assert property (p_reject_cause)
        else $error("bad accept");

    property p_quiet;
        @(posedge clk_i) disable iff (rst_i) !rx_valid_i |=> !mb0_accept_o && !mb0_reject_o;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("answer without frame");

    property p_full_mask;
        @(posedge clk_i) disable iff (rst_i)
            rx_valid_i && mask_low_q == 16'hFFFF && mask_high_q == 16'hE3FF
            && rx_ext_i == ext_cfg |=> mb0_accept_o;
    endproperty
    a_full_mask: assert property (p_full_mask)
        else $error("masked id rejected");

    property p_format_gate;
        @(posedge clk_i) disable iff (rst_i) rx_valid_i && (rx_ext_i != ext_cfg) |=> mb0_reject_o;
    endproperty
    a_format_gate: assert property (p_format_gate)
        else $error("wrong format accepted");

    property p_exact_id;
        @(posedge clk_i) disable iff (rst_i)
            rx_valid_i && rx_ext_i && ext_cfg && (rx_id_i == mb_id) |=> mb0_accept_o;
    endproperty
    a_exact_id: assert property (p_exact_id)
        else $error("exact id rejected");

    property p_fmt_copy;
        @(posedge clk_i) disable iff (rst_i)
            take |=> mb0_rtr_o == $past(rtr_cfg) && mb0_ext_o == $past(ext_cfg);
    endproperty
    a_fmt_copy: assert property (p_fmt_copy)
        else $error("frame format not captured");

    // Bus handshake: exactly one ack per taken request, one cycle later.
    property p_ack_one;
        @(posedge clk_i) disable iff (rst_i) ack_o |=> !ack_o;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack held");

    property p_ack_answer;
        @(posedge clk_i) disable iff (rst_i) req |=> ack_o;
    endproperty
    a_ack_answer: assert property (p_ack_answer)
        else $error("request not answered");

    property p_ack_cause;
        @(posedge clk_i) disable iff (rst_i) !req |=> !ack_o;
    endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("ack without request");

    property p_low_write;
        @(posedge clk_i) disable iff (rst_i)
            wr && hit_low && full_sel |=> mask_low_q == $past(wr_half);
    endproperty
    a_low_write: assert property (p_low_write)
        else $error("low mask write lost");

    property p_high_write;
        @(posedge clk_i) disable iff (rst_i)
            wr && hit_high && full_sel |=> mask_high_q == ($past(wr_half) & CMFC_MASK_HIGH_WR);
    endproperty
    a_high_write: assert property (p_high_write)
        else $error("high mask write wrong");

    property p_low_hold;
        @(posedge clk_i) disable iff (rst_i) !(wr && hit_low) |=> $stable(mask_low_q);
    endproperty
    a_low_hold: assert property (p_low_hold)
        else $error("low mask changed unasked");

    property p_ram_write;
        @(posedge clk_i) disable iff (rst_i)
            ram_we |=> ctrl_ram[$past(ram_idx)] == $past(wr_byte);
    endproperty
    a_ram_write: assert property (p_ram_write)
        else $error("control byte write lost");
endmodule
`default_nettype wire

// ### test/cmfc_node.sv
`timescale 1ns/1ns
`default_nettype none
// ****
// Remote node that hands frames to the filter.
// ****
module cmfc_node (
    input  wire logic        clk_i,
    input  wire logic        send_i,
    input  wire logic [28:0] id_i,
    input  wire logic        ext_i,
    output logic      [28:0] rx_id_o = 29'h0,
    output logic             rx_ext_o = 1'b0,
    output logic             rx_valid_o = 1'b0
);
    // Idle lines toggle, so a stale identifier can never pass for a match.
    always @(posedge clk_i) begin
        rx_valid_o <= send_i;
        rx_id_o    <= send_i ? id_i : ~rx_id_o;
        rx_ext_o   <= send_i ? ext_i : ~rx_ext_o;
    end
endmodule
`default_nettype wire

// ### test/cmfc_filter_tb.sv
`timescale 1ns/1ns
`default_nettype none
module cmfc_filter_tb;
    import cmfc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, snd = 1'b0, nx = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, rd, dat_o;
    logic [28:0] nid = 29'h0, rid;
    logic [3:0] dlc;
    logic ack_o, acc, rej, rtr, ext, rext, rval;
    int errors = 0;
    int cmp_count = 0;
    localparam logic [28:0] ID0 = {8'hA5, 5'h17, 8'h3C, 8'h96};
    localparam int BITN [6] = '{0, 8, 20, 18, 16, 28};
    localparam logic [7:0] MADR [6] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h04, 8'h04};
    localparam logic [15:0] MVAL [6] = '{16'h0100, 16'h0001, 16'h8000, 16'h2000, 16'h0100, 16'h0080};
    always #2 clk_i = ~clk_i;
    cmfc_node i_cmfc_node (.clk_i(clk_i), .send_i(snd), .id_i(nid), .ext_i(nx),
        .rx_id_o(rid), .rx_ext_o(rext), .rx_valid_o(rval));
    cmfc_filter i_cmfc_filter (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(4'hF), .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o),
        .rx_id_i(rid), .rx_ext_i(rext), .rx_rtr_i(1'b0), .rx_valid_i(rval),
        .mb0_accept_o(acc), .mb0_reject_o(rej), .mb0_dlc_o(dlc), .mb0_rtr_o(rtr),
        .mb0_ext_o(ext));
    // ****
    // Bus and frame tasks.
    // ****
    task automatic tally_and_finish;
        $display("%0d comparisons, %0d mismatches", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wait_for(ref logic a, ref logic b);
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (a !== 1'b1 && b !== 1'b1 && n < 20);
        if (n == 20 && a !== 1'b1 && b !== 1'b1) begin
            errors++;
            $display("CHECK FAILED at %0t no answer", $time);
            tally_and_finish();
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
        wait_for(ack_o, ack_o);
        rd = dat_o;
        {cyc, stb} <= 2'b00;
    endtask
    task automatic send(input logic [28:0] id, input logic x, input logic ok);
        @(posedge clk_i);
        {snd, nid, nx} <= {1'b1, id, x};
        @(posedge clk_i);
        snd <= 1'b0;
        wait_for(acc, rej);
        chk({acc, rej}, {ok, !ok});
    endtask
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, CMFC_OFS_MASK_LOW, 0);
        chk(rd, {16'h0, CMFC_MASK_LOW_RST});
        wb(1, 8'h40, 32'hFFFF_FFFF);
        wb(0, 8'h40, 0);
        chk(rd, 32'h0);
        wb(1, CMFC_OFS_MASK_HIGH, 32'h0000_FFFF);
        wb(0, CMFC_OFS_MASK_HIGH, 0);
        chk(rd, {16'h0, CMFC_MASK_HIGH_WR});
        wb(1, CMFC_OFS_MASK_HIGH, 0);
        wb(1, 8'h80, 32'h0F);
        for (int k = 1; k < 4; k++) begin
            wb(1, CMFC_OFS_CTRL_BASE + 8'(k), 0);
        end
        wb(1, 8'h84, 32'hAB);
        wb(1, 8'h85, 32'hA5);
        wb(1, 8'h86, 32'h96);
        wb(1, 8'h87, 32'h3C);
        wb(0, 8'h84, 0);
        chk(rd, 32'hAB);
        $display("register test done");
        send(ID0, 1'b1, 1'b1);
        chk({dlc, rtr, ext}, {CMFC_DLC_MAX, 2'b01});
        send(ID0, 1'b0, 1'b0);
        for (int i = 0; i < 6; i++) begin
            wb(1, MADR[i], {16'h0, MVAL[i]});
            send(ID0 ^ (29'h1 << BITN[i]), 1'b1, 1'b1);
            wb(1, MADR[i], 0);
            send(ID0 ^ (29'h1 << BITN[i]), 1'b1, 1'b0);
        end
        $display("filter test done");
        wb(1, 8'h84, 32'hB3);
        send(ID0 ^ 29'h0003_FFFF, 1'b0, 1'b1);
        chk({rtr, ext}, 2'b10);
        wb(1, CMFC_OFS_MASK_LOW, 32'hFFFF);
        wb(1, CMFC_OFS_MASK_HIGH, 32'hFFFF);
        send(~ID0, 1'b0, 1'b1);
        $display("format test done");
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(0, CMFC_OFS_MASK_HIGH, 0);
        chk(rd, {16'h0, CMFC_MASK_HIGH_RST});
        wb(0, 8'h84, 0);
        chk(rd, 32'hB3);
        $display("reset test done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
